// [rtl/resi_cfg.svh]
/*
 * Constants for the receiver event status and interrupt block: register
 * indices and byte addresses, field positions, reset values and timing.
 * Assumes a 100 MHz system clock and a 32-bit APB register port.
 */
// Notes on behaviour
// - sync flag bit 7 sets on sync word, clears when packet reception ends.
// - preamble-valid bit 6 sets on preamble, clears on sync or sync timeout.
// - preamble-invalid bit 5 sets on missing preamble and clears itself.
// - signal-strength bit 4 follows the above-threshold level.
// - wake-timer bit 3 sets when the wake-up timer expires.
// - low-battery bit 2 latches while disabled, interrupts once enabled.
// - chip-ready bit 1 rises after crystal settling, holds until idle.
// - power-on bit 0 sets on a detected power-on reset.
// - interrupt pin goes low when an enabled flag rises.
// - reading status releases the pin and clears enabled flags.
// - disabled flags are plain status, untouched by reads.
// - status contents after reset are not to be relied on.
// - each flag has an enable bit; one lets it drive the pin.
`ifndef RESI_CFG_SVH
`define RESI_CFG_SVH

// ==========================================================
// register indices and byte addresses (address = index * 4)
`define RESI_IDX_STATUS   8'h04
`define RESI_IDX_ENABLE   8'h06
`define RESI_ADDR_STATUS  {2'b00, `RESI_IDX_STATUS, 2'b00}
`define RESI_ADDR_ENABLE  {2'b00, `RESI_IDX_ENABLE, 2'b00}
`define RESI_ADDR_CTRL    12'h020
`define RESI_ADDR_PEND    12'h024
`define RESI_ADDR_IMASK   12'h028

// ==========================================================
// field positions
`define RESI_BIT_SWDET    7
`define RESI_BIT_PREVAL   6
`define RESI_BIT_PREINV   5
`define RESI_BIT_RSSI     4
`define RESI_BIT_WUT      3
`define RESI_BIT_LBD      2
`define RESI_BIT_CHIPRDY  1
`define RESI_BIT_POR      0
`define RESI_CTRL_XTAL    0
`define RESI_CTRL_RX      1

// ==========================================================
// reset values
`define RESI_RST_FLAGS    8'h00
`define RESI_RST_ENABLE   8'h00
`define RESI_RST_CTRL     2'h0
`define RESI_RST_IMASK    8'h00

// ==========================================================
// timing
`define RESI_CLK_NS       10
`define RESI_SETTLE_NS    1000
`define RESI_SETTLE_CYC   ((`RESI_SETTLE_NS + `RESI_CLK_NS - 1) / `RESI_CLK_NS)

`endif

// [rtl/resi_pkg.sv]
/*
 * Types shared by the receiver event status block: bus request,
 * receiver event bundle and settling state machine states.
 * Assumes the constants header is included by the modules.
 */
package resi_pkg;

	// ==========================================================
	// apb request from the master
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} resi_apb_req_t;

	// ==========================================================
	// receiver event bundle, pulses except rssi_above
	typedef struct packed {
		logic sync_found;
		logic pkt_done;
		logic preamble_det;
		logic sync_timeout;
		logic preamble_invalid;
		logic rssi_above;
		logic wut_expired;
		logic low_batt;
		logic por_det;
	} resi_rx_evt_t;

	typedef enum logic [1:0] {
		S_IDLE,
		S_SETTLE,
		S_READY
	} resi_settle_t;

endpackage

// [rtl/resi_flags.sv]
/*
 * Event flag bank: one flag per bit, set by hardware, cleared by hardware
 * while disabled or by a clearing read while enabled.
 * Assumes set, clear and read-clear vectors are synchronous to i_sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "resi_cfg.svh"
module resi_flags #(
	parameter int W = 8
) (
	input  wire logic         i_sys_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_set,
	input  wire logic [W-1:0] i_clr,
	input  wire logic [W-1:0] i_en,
	input  wire logic [W-1:0] i_rdclr,
	output logic      [W-1:0] o_flags,
	output logic      [W-1:0] o_rise
);
	import resi_pkg::*;

	logic [W-1:0] next_flags;

	// ==========================================================
	// per-bit next value; set always wins so no event is lost
	for (genvar g = 0; g < W; g++) begin : g_bit
		always_comb begin
			if (i_set[g]) begin
				next_flags[g] = 1'b1;
			end else if (i_en[g]) begin
				next_flags[g] = o_flags[g] & ~i_rdclr[g];
			end else begin
				next_flags[g] = o_flags[g] & ~i_clr[g];
			end
		end
	end

	// rising edges feed the pin and the pending register
	assign o_rise = next_flags & ~o_flags;

	// reset loads RESI_RST_FLAGS (all zero), but software must not trust it
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_flags <= W'(`RESI_RST_FLAGS);
		end else begin
			o_flags <= next_flags;
		end
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	a_set_wins: assert property (|i_set |=> ((o_flags & $past(i_set)) == $past(i_set)))
		else $error("flag set lost");
	a_enabled_hold: assert property (((i_en & ~i_rdclr & o_flags) != '0)
		|=> ((o_flags & $past(i_en & ~i_rdclr & o_flags)) == $past(i_en & ~i_rdclr & o_flags)))
		else $error("enabled flag dropped without read");

endmodule
`default_nettype wire

// [rtl/resi_top.sv]
/*
 * Receiver event status register with its enable register, active-low
 * interrupt pin, crystal settling sequencer and a sticky pending/mask pair
 * driving a level interrupt. Registers sit on an APB slave port.
 * Assumes receiver events arrive synchronous to i_sys_clk.
 */
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "resi_cfg.svh"
module resi_top #(
	parameter int unsigned SETTLE_CYC = `RESI_SETTLE_CYC
) (
	input  wire logic                    i_sys_clk,
	input  wire logic                    i_rst,
	input  wire resi_pkg::resi_apb_req_t i_apb,
	input  wire resi_pkg::resi_rx_evt_t  i_evt,
	output logic [31:0]                  o_prdata,
	output logic                         o_pready,
	output logic                         o_pslverr,
	output logic                         o_irq_out_n,
	output logic                         o_irq
);
	import resi_pkg::*;

	// ==========================================================
	// address decode for pslverr, which also gates the write strobes
	function automatic logic is_mapped(input logic [11:0] a);
		return (a == `RESI_ADDR_STATUS) || (a == `RESI_ADDR_ENABLE) ||
			(a == `RESI_ADDR_CTRL) || (a == `RESI_ADDR_PEND) ||
			(a == `RESI_ADDR_IMASK);
	endfunction

	logic        setup;
	logic        done;
	logic        wr_done;
	logic        rd_status_done;
	logic        wr_enable;
	logic        wr_ctrl;
	logic        wr_pend;
	logic        wr_imask;

	logic [7:0]  flags;
	logic [7:0]  rise;
	logic [7:0]  set_v;
	logic [7:0]  clr_v;
	logic [7:0]  rdclr;

	logic [7:0]  enable;
	logic [7:0]  next_enable;
	logic [1:0]  ctrl;
	logic [1:0]  next_ctrl;
	logic [7:0]  pend;
	logic [7:0]  next_pend;
	logic [7:0]  imask;
	logic [7:0]  next_imask;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;

	logic        next_irq_out_n;
	logic        next_irq;
	logic        lbd_arm;
	logic [7:0]  hit;

	resi_settle_t state;
	resi_settle_t next_state;
	logic [15:0]  settle_cnt;
	logic [15:0]  next_settle_cnt;
	logic         both_on;
	logic         rdy_pulse;

	// ==========================================================
	// bus phases; pready is high only in the access cycle
	assign setup   = i_apb.psel & ~i_apb.penable;
	assign done    = i_apb.psel & i_apb.penable & o_pready;
	assign wr_done = done & i_apb.pwrite & ~o_pslverr;
	assign rd_status_done = done & ~i_apb.pwrite &
		(i_apb.paddr == `RESI_ADDR_STATUS);
	assign wr_enable = wr_done & (i_apb.paddr == `RESI_ADDR_ENABLE);
	assign wr_ctrl   = wr_done & (i_apb.paddr == `RESI_ADDR_CTRL);
	assign wr_pend   = wr_done & (i_apb.paddr == `RESI_ADDR_PEND);
	assign wr_imask  = wr_done & (i_apb.paddr == `RESI_ADDR_IMASK);

	// read data is latched in setup; only the bits actually returned
	// are cleared, so an event arriving meanwhile stays visible
	assign rdclr = rd_status_done ? (o_prdata[7:0] & enable) : 8'h00;

	// ==========================================================
	// register next values and read mux
	always_comb begin
		next_enable  = wr_enable ? i_apb.pwdata[7:0] : enable;
		next_ctrl    = wr_ctrl ? i_apb.pwdata[1:0] : ctrl;
		next_imask   = wr_imask ? i_apb.pwdata[7:0] : imask;
		next_pend    = (pend & ~(wr_pend ? i_apb.pwdata[7:0] : 8'h00)) | rise;
		next_prdata  = 32'h0000_0000;
		next_pready  = 1'b0;
		next_pslverr = 1'b0;
		if (setup) begin
			next_pready  = 1'b1;
			next_pslverr = ~is_mapped(i_apb.paddr);
			if (!i_apb.pwrite) begin
				unique case (i_apb.paddr)
					`RESI_ADDR_STATUS: next_prdata = {24'h00_0000, flags};
					`RESI_ADDR_ENABLE: next_prdata = {24'h00_0000, enable};
					`RESI_ADDR_CTRL:   next_prdata = {26'h000_0000,
						(state == S_READY), (state == S_SETTLE), 2'h0, ctrl};
					`RESI_ADDR_PEND:   next_prdata = {24'h00_0000, pend};
					`RESI_ADDR_IMASK:  next_prdata = {24'h00_0000, imask};
					default:           next_prdata = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			enable    <= `RESI_RST_ENABLE;
			ctrl      <= `RESI_RST_CTRL;
			imask     <= `RESI_RST_IMASK;
			pend      <= 8'h00;
			o_prdata  <= 32'h0000_0000;
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			enable    <= next_enable;
			ctrl      <= next_ctrl;
			imask     <= next_imask;
			pend      <= next_pend;
			o_prdata  <= next_prdata;
			o_pready  <= next_pready;
			o_pslverr <= next_pslverr;
		end
	end

	// ==========================================================
	// crystal settling: ready only after both supplies are on long enough
	assign both_on = ctrl[`RESI_CTRL_XTAL] & ctrl[`RESI_CTRL_RX];

	always_comb begin
		next_state      = state;
		next_settle_cnt = settle_cnt;
		rdy_pulse       = 1'b0;
		unique case (state)
			S_IDLE: begin
				next_settle_cnt = 16'h0000;
				if (both_on) begin
					next_state = S_SETTLE;
				end
			end
			S_SETTLE: begin
				if (!both_on) begin
					next_state = S_IDLE;
				end else if (settle_cnt == 16'(SETTLE_CYC - 1)) begin
					next_state = S_READY;
					rdy_pulse  = 1'b1;
				end else begin
					next_settle_cnt = settle_cnt + 16'h0001;
				end
			end
			S_READY: begin
				if (!both_on) begin
					next_state = S_IDLE;
				end
			end
			default: next_state = S_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			state      <= S_IDLE;
			settle_cnt <= 16'h0000;
		end else begin
			state      <= next_state;
			settle_cnt <= next_settle_cnt;
		end
	end

	// ==========================================================
	// per-flag set and hardware clear conditions
	always_comb begin
		set_v = 8'h00;
		clr_v = 8'h00;
		set_v[`RESI_BIT_SWDET]   = i_evt.sync_found;
		clr_v[`RESI_BIT_SWDET]   = i_evt.pkt_done;
		set_v[`RESI_BIT_PREVAL]  = i_evt.preamble_det;
		clr_v[`RESI_BIT_PREVAL]  = i_evt.sync_found | i_evt.sync_timeout;
		// self-clearing: a plain status copy lasts one cycle only
		set_v[`RESI_BIT_PREINV]  = i_evt.preamble_invalid;
		clr_v[`RESI_BIT_PREINV]  = 1'b1;
		set_v[`RESI_BIT_RSSI]    = i_evt.rssi_above;
		clr_v[`RESI_BIT_RSSI]    = ~i_evt.rssi_above;
		set_v[`RESI_BIT_WUT]     = i_evt.wut_expired;
		clr_v[`RESI_BIT_WUT]     = 1'b1;
		// low battery stays latched until an enabled read clears it
		set_v[`RESI_BIT_LBD]     = i_evt.low_batt;
		set_v[`RESI_BIT_CHIPRDY] = rdy_pulse;
		clr_v[`RESI_BIT_CHIPRDY] = (state == S_IDLE);
		set_v[`RESI_BIT_POR]     = i_evt.por_det;
	end

	resi_flags #(
		.W (8)
	) u_flags (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_set     (set_v),
		.i_clr     (clr_v),
		.i_en      (enable),
		.i_rdclr   (rdclr),
		.o_flags   (flags),
		.o_rise    (rise)
	);

	// ==========================================================
	// interrupt pin; a rise in the clearing cycle keeps it low
	assign lbd_arm = wr_enable & i_apb.pwdata[`RESI_BIT_LBD] &
		~enable[`RESI_BIT_LBD] & flags[`RESI_BIT_LBD];

	// an enabled event on the clearing edge shows no rise when its flag is
	// already set, so it is caught here or the host would never see it
	assign hit = (rise & enable) | (set_v & rdclr);

	always_comb begin
		if ((hit != 8'h00) || lbd_arm) begin
			next_irq_out_n = 1'b0;
		end else if (rd_status_done) begin
			next_irq_out_n = 1'b1;
		end else begin
			next_irq_out_n = o_irq_out_n;
		end
		next_irq = (next_pend & next_imask) != 8'h00;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_irq_out_n <= 1'b1;
			o_irq       <= 1'b0;
		end else begin
			o_irq_out_n <= next_irq_out_n;
			o_irq       <= next_irq;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	sequence s_status_setup;
		setup && !i_apb.pwrite && (i_apb.paddr == `RESI_ADDR_STATUS);
	endsequence
	sequence s_status_access;
		i_apb.psel && i_apb.penable && o_pready;
	endsequence

	a_status_answer: assert property (s_status_setup |=> o_pready && !o_pslverr
		&& (o_prdata[7:0] == $past(flags)))
		else $error("status read answer wrong");
	a_read_release: assert property (s_status_setup ##1 s_status_access
		##0 (hit == 8'h00) ##0 !lbd_arm |=> o_irq_out_n)
		else $error("pin not released by status read");
	a_irq_on_rise: assert property (((rise & enable) != 8'h00) |=> !o_irq_out_n)
		else $error("pin not pulled on enabled rise");
	a_no_loss: assert property (rd_status_done && (hit != 8'h00)
		|=> !o_irq_out_n && ((flags & $past(hit)) == $past(hit)))
		else $error("event lost in clearing read");
	a_plain_kept: assert property (rd_status_done && !enable[`RESI_BIT_LBD]
		&& flags[`RESI_BIT_LBD] |=> flags[`RESI_BIT_LBD])
		else $error("disabled flag cleared by read");
	a_sync_clear: assert property (!enable[`RESI_BIT_SWDET] && i_evt.pkt_done
		&& !i_evt.sync_found |=> !flags[`RESI_BIT_SWDET])
		else $error("sync flag not cleared at packet end");
	a_preval_clear: assert property (!enable[`RESI_BIT_PREVAL] && !i_evt.preamble_det
		&& (i_evt.sync_found || i_evt.sync_timeout) |=> !flags[`RESI_BIT_PREVAL])
		else $error("preamble flag not cleared");
	a_preinv_pulse: assert property (!enable[`RESI_BIT_PREINV]
		&& i_evt.preamble_invalid ##1 !i_evt.preamble_invalid
		|=> !flags[`RESI_BIT_PREINV])
		else $error("invalid preamble flag not self clearing");
	a_rssi_level: assert property (!enable[`RESI_BIT_RSSI]
		|=> flags[`RESI_BIT_RSSI] == $past(i_evt.rssi_above))
		else $error("rssi flag not following level");
	a_wut_set: assert property (i_evt.wut_expired |=> flags[`RESI_BIT_WUT])
		else $error("wake flag not set");
	a_lbd_arm: assert property (lbd_arm |=> !o_irq_out_n && enable[`RESI_BIT_LBD])
		else $error("latched low battery not raised on enable");
	a_chip_ready: assert property (rdy_pulse |=> flags[`RESI_BIT_CHIPRDY]
		&& (state == S_READY))
		else $error("chip ready not raised after settling");
	// settling cycles counted apart from the sequencer's own counter
	logic [15:0] settle_seen;
	logic [15:0] next_settle_seen;
	assign next_settle_seen = (state == S_SETTLE) ? (settle_seen + 16'h0001) : 16'h0000;
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			settle_seen <= 16'h0000;
		end else begin
			settle_seen <= next_settle_seen;
		end
	end

	a_settle_len: assert property ($rose(state == S_READY)
		|-> (settle_seen == 16'(SETTLE_CYC)))
		else $error("settling too short");
	a_por_set: assert property (i_evt.por_det |=> flags[`RESI_BIT_POR])
		else $error("power-on flag not set");
	a_lvl_irq: assert property (o_irq == ((pend & imask) != 8'h00))
		else $error("level interrupt wrong");

endmodule
`default_nettype wire

// [testbench/resi_host_model.sv]
/*
 * Host controller model: runs one APB transfer per request, returns read
 * data and the error flag, and lets the bus go between transfers.
 * Assumes a new request only after the previous one reported done.
 */
`timescale 1ns/1ps
`default_nettype none
module resi_host_model (
	input  wire logic                    i_sys_clk,
	input  wire logic                    i_rst,
	input  wire logic                    i_go,
	input  wire logic                    i_write,
	input  wire logic [11:0]             i_addr,
	input  wire logic [31:0]             i_wdata,
	input  wire logic [31:0]             i_prdata,
	input  wire logic                    i_pready,
	input  wire logic                    i_pslverr,
	output var  resi_pkg::resi_apb_req_t o_apb,
	output logic                         o_done,
	output logic [31:0]                  o_rdata,
	output logic                         o_err
);
	import resi_pkg::*;

	// ==========================================================
	// transfer sequencer: setup, then access held until pready
	always_ff @(posedge i_sys_clk) begin
		o_done <= 1'b0;
		if (i_rst) begin
			o_apb <= '0;
		end else if (o_apb.psel && !o_apb.penable) begin
			o_apb.penable <= 1'b1;
		end else if (o_apb.penable && i_pready) begin
			// data taken only at the sampling edge, then the bus is let go
			o_rdata <= i_prdata;
			o_err <= i_pslverr;
			o_done <= 1'b1;
			o_apb.psel <= 1'b0;
			o_apb.penable <= 1'b0;
			o_apb.paddr <= ~o_apb.paddr;   // released lines lose the old value
			o_apb.pwdata <= ~o_apb.pwdata;
		end else if (i_go && !o_apb.psel) begin
			o_apb <= '{1'b1, 1'b0, i_write, i_addr, i_wdata};
		end
	end
endmodule
`default_nettype wire

// [testbench/test_rx_event_status_irq.sv]
/*
 * Self-checking bench for the receiver event status block: event flags,
 * enable gating, read clearing, the pin, settling and pending/mask.
 * Assumes the host model owns the APB port; the bench drives events.
 */
`timescale 1ns/1ps
`default_nettype none
`include "resi_cfg.svh"
module test_rx_event_status_irq;
	import resi_pkg::*;
	localparam int unsigned SETTLE = 20;
	localparam logic [11:0] A_ST = `RESI_ADDR_STATUS;
	localparam logic [11:0] A_EN = `RESI_ADDR_ENABLE;
	logic          sys_clk, rst, go, wr, done, err, pready, pslverr, irq_n, irq;
	logic [11:0]   addr;
	logic [31:0]   wdata, prdata, rdata;
	resi_apb_req_t apb;
	resi_rx_evt_t  evt;
	int            err_count, total_checks, cyc;

	resi_top #(.SETTLE_CYC(SETTLE)) i_dut (.i_sys_clk(sys_clk), .i_rst(rst), .i_apb(apb),
		.i_evt(evt), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.o_irq_out_n(irq_n), .o_irq(irq));
	resi_host_model i_host (.i_sys_clk(sys_clk), .i_rst(rst), .i_go(go), .i_write(wr),
		.i_addr(addr), .i_wdata(wdata), .i_prdata(prdata), .i_pready(pready),
		.i_pslverr(pslverr), .o_apb(apb), .o_done(done), .o_rdata(rdata), .o_err(err));

	// ==========================================================
	// clock and hang guard, sized well past the whole sequence
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			wrap_up();
		end
	end

	// ==========================================================
	// shared helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	// waits for the answer however long it takes; only the hang guard ends it
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		go <= 1'b1;
		wr <= w;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk);
		go <= 1'b0;
		do begin
			@(posedge sys_clk);
			#1;
		end while (done !== 1'b1);
	endtask
	task automatic rd(input logic [11:0] a);
		xfer(1'b0, a, 32'h0);
	endtask
	task automatic wrt(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	// events are one-cycle pulses; two spare edges let flag and pin land
	task automatic pulse(input logic [8:0] m);
		@(posedge sys_clk);
		evt <= resi_rx_evt_t'(evt | m);
		@(posedge sys_clk);
		evt <= resi_rx_evt_t'(evt & ~m);
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	task automatic settle1();
		@(posedge sys_clk);
		#1;
	endtask

	// ==========================================================
	// scenarios
	task automatic t_regs();
		check({31'h0, irq_n}, 32'h1);
		rd(A_EN);
		check(rdata, 32'h0);
		wrt(A_EN, 32'hFF);
		rd(A_EN);
		check(rdata, 32'hFF);
		rd(12'h0FC);
		check({31'h0, err}, 32'h1);
		check(rdata, 32'h0);
		$display("test regs finished");
	endtask
	task automatic t_enabled();
		// wake and invalid-preamble are serviced as interrupts here; t_status polls them and sees them self-clear
		logic [8:0] m [6] = '{9'h001, 9'h002, 9'h004, 9'h010, 9'h040, 9'h100};
		logic [7:0] b [6] = '{8'h01, 8'h04, 8'h08, 8'h20, 8'h40, 8'h80};
		for (int i = 0; i < 6; i++) begin
			pulse(m[i]);
			check({31'h0, irq_n}, 32'h0);
			rd(A_ST);
			check(rdata, {24'h0, b[i]});
			settle1();
			check({31'h0, irq_n}, 32'h1);
			rd(A_ST);
			check(rdata, 32'h0);
		end
		$display("test enabled finished");
	endtask
	task automatic t_status();
		wrt(A_EN, 32'h0);
		pulse(9'h040);
		check({31'h0, irq_n}, 32'h1);
		rd(A_ST);
		check(rdata, 32'h40);
		rd(A_ST);
		check(rdata, 32'h40);
		pulse(9'h100);
		rd(A_ST);
		check(rdata, 32'h80);
		pulse(9'h080);
		rd(A_ST);
		check(rdata, 32'h0);
		pulse(9'h040);
		pulse(9'h020);
		rd(A_ST);
		check(rdata, 32'h0);
		pulse(9'h014);
		rd(A_ST);
		check(rdata, 32'h0);
		@(posedge sys_clk);
		evt.rssi_above <= 1'b1;
		rd(A_ST);
		check(rdata, 32'h10);
		rd(A_ST);
		check(rdata, 32'h10);
		@(posedge sys_clk);
		evt.rssi_above <= 1'b0;
		rd(A_ST);
		check(rdata, 32'h0);
		$display("test status finished");
	endtask
	task automatic t_lowbatt();
		pulse(9'h002);
		check({31'h0, irq_n}, 32'h1);
		rd(A_ST);
		check(rdata, 32'h04);
		wrt(A_EN, 32'h04);
		settle1();
		check({31'h0, irq_n}, 32'h0);
		rd(A_ST);
		check(rdata, 32'h04);
		rd(A_ST);
		check(rdata, 32'h0);
		wrt(A_EN, 32'h0);
		$display("test low battery finished");
	endtask
	task automatic t_ready();
		wrt(`RESI_ADDR_CTRL, 32'h3);
		rd(A_ST);
		check(rdata, 32'h0);
		repeat (SETTLE + 4) @(posedge sys_clk);
		rd(A_ST);
		check(rdata, 32'h02);
		rd(`RESI_ADDR_CTRL);
		check(rdata, 32'h23);
		wrt(`RESI_ADDR_CTRL, 32'h1);
		rd(A_ST);
		check(rdata, 32'h0);
		$display("test ready finished");
	endtask
	task automatic t_race();
		wrt(A_EN, 32'h01);
		pulse(9'h001);
		// second event lands on the very edge that read-clears
		fork
			rd(A_ST);
			begin
				repeat (3) @(posedge sys_clk);
				evt.por_det <= 1'b1;
				@(posedge sys_clk);
				evt.por_det <= 1'b0;
			end
		join
		check(rdata, 32'h01);
		settle1();
		check({31'h0, irq_n}, 32'h0);
		rd(A_ST);
		check(rdata, 32'h01);
		wrt(A_EN, 32'h0);
		$display("test race finished");
	endtask
	task automatic t_pend();
		wrt(`RESI_ADDR_PEND, 32'hFF);
		wrt(`RESI_ADDR_IMASK, 32'h0);
		pulse(9'h004);
		check({31'h0, irq}, 32'h0);
		rd(`RESI_ADDR_PEND);
		check(rdata, 32'h08);
		wrt(`RESI_ADDR_IMASK, 32'h08);
		settle1();
		check({31'h0, irq}, 32'h1);
		wrt(`RESI_ADDR_PEND, 32'h08);
		settle1();
		check({31'h0, irq}, 32'h0);
		$display("test pending finished");
	endtask

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// main sequence; flags are not read before any event has set them
	initial begin
		{go, wr, addr, wdata, err_count, total_checks, cyc} = '0;
		evt = '0;
		rst = 1'b1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		settle1();
		t_regs();
		t_enabled();
		t_status();
		t_lowbatt();
		t_ready();
		t_race();
		t_pend();
		wrap_up();
	end
endmodule
`default_nettype wire
